//--- hw/ttx_map.svh
// Named opcodes, condition code bit positions and reset values.
// Assumes inclusion by bare name from every file that decodes or checks.
`ifndef TTX_MAP_SVH
`define TTX_MAP_SVH

// Opcodes of the operand test group and the transfers
`define TTX_OP_TEST_DIR     8'h3D
`define TTX_OP_TEST_ACC     8'h4D
`define TTX_OP_TEST_XLO     8'h5D
`define TTX_OP_TEST_IDX1    8'h6D
`define TTX_OP_TEST_IDX     8'h7D
`define TTX_OP_PREFIX       8'h9E
`define TTX_OP_SP_TO_HX     8'h95
`define TTX_OP_XLO_TO_ACC   8'h9F
`define TTX_OP_HX_TO_SP     8'h94

// Opcodes for the extra indexed and move forms
`define TTX_OP_TEST_IDX2    8'h0D
`define TTX_OP_TEST_IDXP    8'h1D
`define TTX_OP_TEST_IDX1P   8'h2D
`define TTX_OP_MOVE_IMD     8'h6E
`define TTX_OP_MOVE_IDXP    8'h7E

// Condition code bit positions
`define TTX_CC_V            7
`define TTX_CC_H            4
`define TTX_CC_I            3
`define TTX_CC_N            2
`define TTX_CC_Z            1
`define TTX_CC_C            0

// Reset values and constants
`define TTX_CC_RESET        8'h68
`define TTX_SP_RESET        16'h00FF
`define TTX_HX_RESET        16'h0000
`define TTX_ACC_RESET       8'h00
`define TTX_TEST_REF        8'h00
`define TTX_ZERO8           8'h00
`define TTX_ZERO16          16'h0000
`define TTX_ONE16           16'h0001
`define TTX_NOFS_NONE       2'h0
`define TTX_NOFS_ONE        2'h1
`define TTX_NOFS_TWO        2'h2

`endif

//--- hw/ttx_pkg.sv
// Types shared by the sequencer and the address adder.
// Assumes nothing beyond a SystemVerilog compiler.
package ttx_pkg;

  typedef enum logic [3:0] {
    st_opc, st_pre, st_ofsh, st_ofsl, st_read, st_dst, st_write, st_xfer
  } ttx_state_t;

  typedef enum logic [2:0] {
    direct_mode, indexed_mode, indexed_short_offset_mode,
    indexed_long_offset_mode, stack_short_offset_mode
  } ttx_mode_t;

  typedef enum logic [2:0] {
    op_none, op_operand_zero_test, op_accum_zero_test, op_index_low_zero_test,
    op_stackptr_to_indexpair, op_index_low_to_accum, op_indexpair_to_stackptr, op_move
  } ttx_kind_t;

  typedef struct packed {
    ttx_kind_t kind;
    ttx_mode_t mode;
    logic [1:0] nofs;
    logic       postinc;
  } ttx_dec_t;

endpackage

//--- hw/ttx_ea_if.sv
// Interface between the sequencer and the effective address adder.
// Assumes one clock domain; carries combinational signals only.
`timescale 1ns/100ps
interface ttx_ea_if;
  import ttx_pkg::*;
  ttx_mode_t   mode;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [15:0] ofs;
  logic [15:0] ea;
  modport calc (input mode, hx, sp, ofs, output ea);
  modport user (output mode, hx, sp, ofs, input ea);
endinterface

//--- hw/ttx_ea.sv
// Effective address adder for direct, indexed and stack-relative forms.
// Assumes the offset arrives zero-extended unless the long form is used.
`timescale 1ns/100ps
`include "ttx_map.svh"
module ttx_ea (
  ttx_ea_if.calc eif
);
  import ttx_pkg::*;

  // Address per addressing form
  always_comb begin
    case (eif.mode)
      direct_mode:               eif.ea = {`TTX_ZERO8, eif.ofs[7:0]};
      indexed_mode:              eif.ea = eif.hx;
      indexed_short_offset_mode: eif.ea = eif.hx + {`TTX_ZERO8, eif.ofs[7:0]};
      indexed_long_offset_mode:  eif.ea = eif.hx + eif.ofs;
      stack_short_offset_mode:   eif.ea = eif.sp + {`TTX_ZERO8, eif.ofs[7:0]};
      default:                   eif.ea = eif.hx;
    endcase
  end

endmodule // ttx_ea

//--- hw/ttx_core.sv
// Sequencer for the operand test, the register transfers and the indexed forms.
// Assumes one instruction byte per cycle at most and a memory that answers a read in the same cycle.
`timescale 1ns/100ps
`include "ttx_map.svh"

module ttx_core (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ins_valid,
  input  wire logic [7:0]  ins_byte,
  output logic             ins_ready,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic [7:0]       acc_out,
  output logic [15:0]      hx_out,
  output logic [15:0]      sp_out,
  output logic [7:0]       condition_code_out,
  output logic             instr_done,
  output logic             illegal_op
);
  import ttx_pkg::*;

  ttx_state_t  state_reg, state_next;
  ttx_kind_t   kind_reg;
  ttx_mode_t   mode_reg;
  logic        postinc_reg;
  logic [7:0]  ofs_hi_reg;
  logic [7:0]  acc_reg;
  logic [15:0] hx_reg;
  logic [15:0] sp_reg;
  logic [7:0]  condition_code_reg;
  logic [15:0] mem_addr_reg;
  logic [7:0]  mem_wdata_reg;
  logic        ins_ready_reg, mem_rd_reg, mem_wr_reg, done_reg, illegal_reg;
  logic        take, fin, bad, test_en;
  logic [7:0]  test_val;
  ttx_dec_t    dec_now;

  ttx_ea_if eif ();
  ttx_ea u_ea (.eif(eif));

  // Opcode decode, plain or after the prefix byte
  function automatic ttx_dec_t decode_op(input logic [7:0] op, input logic pre);
    ttx_dec_t d;
    d = '{op_none, direct_mode, `TTX_NOFS_NONE, 1'b0};
    if (pre) begin
      if (op == `TTX_OP_TEST_IDX1) d = '{op_operand_zero_test, stack_short_offset_mode, `TTX_NOFS_ONE, 1'b0};
    end else begin
      case (op)
        `TTX_OP_TEST_DIR:   d = '{op_operand_zero_test, direct_mode, `TTX_NOFS_ONE, 1'b0};
        `TTX_OP_TEST_ACC:   d = '{op_accum_zero_test, direct_mode, `TTX_NOFS_NONE, 1'b0};
        `TTX_OP_TEST_XLO:   d = '{op_index_low_zero_test, direct_mode, `TTX_NOFS_NONE, 1'b0};
        `TTX_OP_TEST_IDX1:  d = '{op_operand_zero_test, indexed_short_offset_mode, `TTX_NOFS_ONE, 1'b0};
        `TTX_OP_TEST_IDX:   d = '{op_operand_zero_test, indexed_mode, `TTX_NOFS_NONE, 1'b0};
        `TTX_OP_TEST_IDX2:  d = '{op_operand_zero_test, indexed_long_offset_mode, `TTX_NOFS_TWO, 1'b0};
        `TTX_OP_TEST_IDXP:  d = '{op_operand_zero_test, indexed_mode, `TTX_NOFS_NONE, 1'b1};
        `TTX_OP_TEST_IDX1P: d = '{op_operand_zero_test, indexed_short_offset_mode, `TTX_NOFS_ONE, 1'b1};
        `TTX_OP_MOVE_IMD:   d = '{op_move, direct_mode, `TTX_NOFS_ONE, 1'b0};
        `TTX_OP_MOVE_IDXP:  d = '{op_move, indexed_mode, `TTX_NOFS_NONE, 1'b1};
        `TTX_OP_SP_TO_HX:   d = '{op_stackptr_to_indexpair, direct_mode, `TTX_NOFS_NONE, 1'b0};
        `TTX_OP_XLO_TO_ACC: d = '{op_index_low_to_accum, direct_mode, `TTX_NOFS_NONE, 1'b0};
        `TTX_OP_HX_TO_SP:   d = '{op_indexpair_to_stackptr, direct_mode, `TTX_NOFS_NONE, 1'b0};
        default:            d = '{op_none, direct_mode, `TTX_NOFS_NONE, 1'b0};
      endcase
    end
    return d;
  endfunction

  // Byte handshake and current decode
  assign take    = ins_valid && ins_ready_reg;
  assign dec_now = decode_op(ins_byte, state_reg == st_pre);

  // Address adder inputs
  assign eif.mode = (state_reg == st_ofsl) ? mode_reg : dec_now.mode;
  assign eif.hx   = hx_reg;
  assign eif.sp   = sp_reg;
  assign eif.ofs  = (mode_reg == indexed_long_offset_mode) ? {ofs_hi_reg, ins_byte} : {`TTX_ZERO8, ins_byte};

  // Sequencer next state, completion and illegal detection
  always_comb begin
    state_next = state_reg;
    fin = 1'b0;
    bad = 1'b0;
    case (state_reg)
      st_opc: if (take) begin
        if (ins_byte == `TTX_OP_PREFIX) begin
          state_next = st_pre;
        end else begin
          case (dec_now.kind)
            op_none: bad = 1'b1;
            op_accum_zero_test, op_index_low_zero_test, op_index_low_to_accum: fin = 1'b1;
            op_stackptr_to_indexpair, op_indexpair_to_stackptr: state_next = st_xfer;
            default: begin
              if (dec_now.nofs == `TTX_NOFS_TWO) state_next = st_ofsh;
              else if (dec_now.nofs == `TTX_NOFS_ONE) state_next = st_ofsl;
              else state_next = st_read;
            end
          endcase
        end
      end
      st_pre: if (take) begin
        if (dec_now.kind == op_none) begin
          bad = 1'b1;
          state_next = st_opc;
        end else begin
          state_next = st_ofsl;
        end
      end
      st_ofsh: if (take) state_next = st_ofsl;
      st_ofsl: if (take) state_next = (kind_reg == op_move) ? st_dst : st_read;
      st_read: begin
        if (kind_reg == op_move) begin
          state_next = st_dst;
        end else begin
          fin = 1'b1;
          state_next = st_opc;
        end
      end
      st_dst: if (take) state_next = st_write;
      st_write, st_xfer: begin
        fin = 1'b1;
        state_next = st_opc;
      end
      default: state_next = st_opc;
    endcase
  end

  // Value under test and its enable
  always_comb begin
    test_en  = 1'b0;
    test_val = acc_reg;
    if (state_reg == st_opc && take && dec_now.kind == op_accum_zero_test) begin
      test_en = 1'b1;
    end else if (state_reg == st_opc && take && dec_now.kind == op_index_low_zero_test) begin
      test_en  = 1'b1;
      test_val = hx_reg[7:0];
    end else if (state_reg == st_read && kind_reg == op_operand_zero_test) begin
      test_en  = 1'b1;
      test_val = mem_rdata;
    end
  end

  // Sequencer state and port strobes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= st_opc;
      ins_ready_reg <= 1'b1;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ins_ready_reg <= (state_next == st_opc) || (state_next == st_pre) || (state_next == st_ofsh) ||
                       (state_next == st_ofsl) || (state_next == st_dst);
      mem_rd_reg    <= (state_next == st_read);
      mem_wr_reg    <= (state_next == st_write);
      done_reg      <= fin;
      illegal_reg   <= bad;
    end
  end

  // Latched decode and high offset byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      kind_reg    <= op_none;
      mode_reg    <= direct_mode;
      postinc_reg <= 1'b0;
      ofs_hi_reg  <= `TTX_ZERO8;
    end else begin
      if ((state_reg == st_opc || state_reg == st_pre) && take) begin
        kind_reg    <= dec_now.kind;
        mode_reg    <= dec_now.mode;
        postinc_reg <= dec_now.postinc;
      end
      if (state_reg == st_ofsh && take) ofs_hi_reg <= ins_byte;
    end
  end

  // Memory address and write data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr_reg  <= `TTX_ZERO16;
      mem_wdata_reg <= `TTX_ZERO8;
    end else begin
      if ((state_reg == st_opc && take && state_next == st_read) ||
          (state_reg == st_ofsl && take && kind_reg != op_move)) begin
        mem_addr_reg <= eif.ea;
      end else if (state_reg == st_dst && take) begin
        mem_addr_reg <= {`TTX_ZERO8, ins_byte};
      end
      if (state_reg == st_ofsl && take && kind_reg == op_move) mem_wdata_reg <= ins_byte;
      else if (state_reg == st_read && kind_reg == op_move) mem_wdata_reg <= mem_rdata;
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) acc_reg <= `TTX_ACC_RESET;
    else if (state_reg == st_opc && take && dec_now.kind == op_index_low_to_accum) acc_reg <= hx_reg[7:0];
  end

  // Index pair: transfer from stack pointer or post-increment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) hx_reg <= `TTX_HX_RESET;
    else if (state_reg == st_xfer && kind_reg == op_stackptr_to_indexpair) hx_reg <= sp_reg + `TTX_ONE16;
    else if (state_reg == st_read && postinc_reg) hx_reg <= hx_reg + `TTX_ONE16;
  end

  // Stack pointer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) sp_reg <= `TTX_SP_RESET;
    else if (state_reg == st_xfer && kind_reg == op_indexpair_to_stackptr) sp_reg <= hx_reg - `TTX_ONE16;
  end

  // Condition codes: only the test touches N, Z and V
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      condition_code_reg <= `TTX_CC_RESET;
    end else if (test_en) begin
      condition_code_reg[`TTX_CC_N] <= test_val[7];
      condition_code_reg[`TTX_CC_Z] <= (test_val == `TTX_TEST_REF);
      condition_code_reg[`TTX_CC_V] <= 1'b0;
    end
  end

  // Ports straight from flip-flops
  assign ins_ready          = ins_ready_reg;
  assign mem_rd             = mem_rd_reg;
  assign mem_wr             = mem_wr_reg;
  assign mem_addr           = mem_addr_reg;
  assign mem_wdata          = mem_wdata_reg;
  assign acc_out            = acc_reg;
  assign hx_out             = hx_reg;
  assign sp_out             = sp_reg;
  assign condition_code_out = condition_code_reg;
  assign instr_done         = done_reg;
  assign illegal_op         = illegal_reg;

  // Checks on flags, timing, transfers and addressing
  test_flags_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_read && kind_reg == op_operand_zero_test) |=>
      condition_code_reg[`TTX_CC_N] == $past(mem_rdata[7]) &&
      condition_code_reg[`TTX_CC_Z] == ($past(mem_rdata) == `TTX_TEST_REF) &&
      !condition_code_reg[`TTX_CC_V] && $stable(condition_code_reg[`TTX_CC_H]) &&
      $stable(condition_code_reg[`TTX_CC_I]) && $stable(condition_code_reg[`TTX_CC_C]))
    else $error("operand test flags wrong");
  direct_timing_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_opc && take && ins_byte == `TTX_OP_TEST_DIR) ##1 take |=> fin)
    else $error("direct test not done in three cycles");
  indexed_timing_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_opc && take && ins_byte == `TTX_OP_TEST_IDX) |=> fin ##1 instr_done)
    else $error("indexed test not done in two cycles");
  stack_timing_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_opc && take && ins_byte == `TTX_OP_PREFIX) ##1 (take && ins_byte == `TTX_OP_TEST_IDX1)
      ##1 take |=> fin && mem_addr_reg == sp_reg + {`TTX_ZERO8, $past(ins_byte)})
    else $error("stack test timing or address wrong");
  sp_to_hx_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_opc && take && ins_byte == `TTX_OP_SP_TO_HX) |=> ##1
      hx_reg == $past(sp_reg) + `TTX_ONE16 && condition_code_reg == $past(condition_code_reg, 2) && instr_done)
    else $error("stack pointer to index pair wrong");
  xlo_to_acc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_opc && take && ins_byte == `TTX_OP_XLO_TO_ACC) |=>
      acc_reg == $past(hx_reg[7:0]) && $stable(condition_code_reg) && instr_done)
    else $error("index low to accumulator wrong");
  hx_to_sp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_xfer && kind_reg == op_indexpair_to_stackptr) |=>
      sp_reg == $past(hx_reg) - `TTX_ONE16 && $stable(condition_code_reg))
    else $error("index pair to stack pointer wrong");
  postinc_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mem_rd_reg && postinc_reg && mode_reg == indexed_mode) |->
      mem_addr_reg == hx_reg ##1 hx_reg == $past(hx_reg) + `TTX_ONE16)
    else $error("post-increment read wrong");
  short_offset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_ofsl && take && mode_reg == indexed_short_offset_mode) |=>
      mem_rd_reg && mem_addr_reg == $past(hx_reg) + {`TTX_ZERO8, $past(ins_byte)})
    else $error("short offset address wrong");
  long_offset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_ofsl && take && mode_reg == indexed_long_offset_mode) |=>
      mem_addr_reg == $past(hx_reg) + {$past(ofs_hi_reg), $past(ins_byte)})
    else $error("long offset address wrong");
  move_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == st_dst && take) |=> mem_wr_reg && mem_addr_reg[15:8] == `TTX_ZERO8 &&
      mem_addr_reg[7:0] == $past(ins_byte) ##1 instr_done)
    else $error("move to direct wrong");

endmodule // ttx_core

//--- tb/ttx_mem_model.sv
// Memory model standing on the far side of the test-and-transfer sequencer.
// Assumes reads are answered in the same cycle and writes land at the clock edge.
`timescale 1ns/100ps
module ttx_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  // Fill with an address-derived pattern
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8];
    end
  end

  // Read answers at once; an idle bus shows the inverse of the last byte, never a stale copy
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

  // Writes land at the edge; remember the last byte read
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last_q <= mem[mem_addr];
    end
  end
endmodule // ttx_mem_model

//--- tb/test_and_transfer_ops_bench.sv
// Self-checking bench for the test-and-transfer sequencer with a memory model.
// Assumes a 10 MHz clock and the opcode names of the shared map header.
`timescale 1ns/100ps
`include "ttx_map.svh"
module test_and_transfer_ops_bench;
  logic        clk_sys, reset_n, ins_valid, ins_ready, mem_rd, mem_wr, instr_done, illegal_op;
  logic [7:0]  ins_byte, mem_wdata, mem_rdata, acc_out, condition_code_out, exp_a, exp_cc, wr_data;
  logic [15:0] mem_addr, hx_out, sp_out, exp_hx, exp_sp, rd_addr, wr_addr;
  int          cyc = 0, rd_cnt = 0, wr_cnt = 0, done_cnt = 0, ill_cnt = 0, done_cyc = 0;
  int          mismatches = 0, checked = 0, seed = 32'h1839;

  ttx_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .ins_valid(ins_valid), .ins_byte(ins_byte),
    .ins_ready(ins_ready), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .acc_out(acc_out), .hx_out(hx_out), .sp_out(sp_out),
    .condition_code_out(condition_code_out), .instr_done(instr_done), .illegal_op(illegal_op));
  ttx_mem_model mem_i (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // Clock and edge counter
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Log bus and completion events mid-cycle, where outputs are settled
  always @(negedge clk_sys) begin
    if (mem_rd) begin
      rd_cnt++;
      rd_addr = mem_addr;
    end
    if (mem_wr) begin
      wr_cnt++;
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end
    if (instr_done) begin
      done_cnt++;
      done_cyc = cyc;
    end
    if (illegal_op) ill_cnt++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run length
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // Test flags: N and Z from the operand, V cleared, H I C kept
  function automatic logic [7:0] tflags(input logic [7:0] v);
    tflags = {1'b0, exp_cc[6:3], v[7], v == 8'h00, exp_cc[0]};
  endfunction

  task automatic shadow_reset();
    exp_a = 8'h00;
    exp_hx = 16'h0000;
    exp_sp = 16'h00FF;
    exp_cc = 8'h68;
  endtask

  task automatic chk_reset();
    chk({8'h00, acc_out}, 16'h0000);
    chk(hx_out, 16'h0000);
    chk(sp_out, 16'h00FF);
    chk({8'h00, condition_code_out}, 16'h0068);
    chk({12'h000, ins_ready, mem_rd, mem_wr, instr_done | illegal_op}, 16'h0008);
  endtask

  // Offer one byte; it is taken at the edge after a cycle with ins_ready high
  task automatic send(input logic [7:0] b, output int tk);
    logic r;
    ins_valid <= 1'b1;
    ins_byte  <= b;
    r = 1'b0;
    while (!r) begin
      @(negedge clk_sys);
      r = ins_ready;
      tk = cyc;
      @(posedge clk_sys);
    end
  endtask

  // Send one instruction, wait for its end, compare timing, bus traffic and registers
  task automatic run(input logic [31:0] bs, input int nb, input int ncyc, input int nrd,
                     input logic [15:0] ra, input int nwr, input logic [15:0] wa, input logic [7:0] wd,
                     input int okd);
    int d0, r0, w0, i0, tk, t0, n;
    d0 = done_cnt;
    r0 = rd_cnt;
    w0 = wr_cnt;
    i0 = ill_cnt;
    t0 = 0;
    for (int i = 0; i < nb; i++) begin
      send(bs[31-8*i -: 8], tk);
      if (i == 0) t0 = tk;
    end
    ins_valid <= 1'b0;
    ins_byte  <= ~bs[31-8*(nb-1) -: 8];
    n = 0;
    while (done_cnt == d0 && ill_cnt == i0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    chk(16'(done_cnt - d0), 16'(okd));
    chk(16'(ill_cnt - i0), 16'(1 - okd));
    if (okd == 1) chk(16'(done_cyc - t0), 16'(ncyc));
    chk(16'(rd_cnt - r0), 16'(nrd));
    if (nrd > 0) chk(rd_addr, ra);
    chk(16'(wr_cnt - w0), 16'(nwr));
    if (nwr > 0) chk(wr_addr, wa);
    if (nwr > 0) chk({8'h00, wr_data}, {8'h00, wd});
    chk({8'h00, acc_out}, {8'h00, exp_a});
    chk(hx_out, exp_hx);
    chk(sp_out, exp_sp);
    chk({8'h00, condition_code_out}, {8'h00, exp_cc});
    @(posedge clk_sys);
  endtask

  // Work out what one opcode must do, then run it with random offsets and operands
  task automatic do_op(input logic [7:0] op);
    logic [7:0]  f, v, d;
    logic [15:0] a;
    f = 8'($random(seed));
    v = 8'($random(seed));
    d = 8'($random(seed));
    if (d[1:0] == 2'h0) v = 8'h00;
    if (d[1:0] == 2'h1) v = 8'h80;
    case (op)
      `TTX_OP_TEST_DIR, `TTX_OP_TEST_IDX1, `TTX_OP_TEST_IDX1P: begin
        a = (op == `TTX_OP_TEST_DIR) ? {8'h00, f} : exp_hx + {8'h00, f};
        mem_i.mem[a] = v;
        exp_cc = tflags(v);
        if (op == `TTX_OP_TEST_IDX1P) exp_hx = exp_hx + 16'h0001;
        run({op, f, 16'h0000}, 2, 3, 1, a, 0, 16'h0000, 8'h00, 1);
      end
      `TTX_OP_TEST_IDX, `TTX_OP_TEST_IDXP: begin
        a = exp_hx;
        mem_i.mem[a] = v;
        exp_cc = tflags(v);
        if (op == `TTX_OP_TEST_IDXP) exp_hx = exp_hx + 16'h0001;
        run({op, 24'h000000}, 1, 2, 1, a, 0, 16'h0000, 8'h00, 1);
      end
      `TTX_OP_TEST_IDX2: begin
        a = exp_hx + {f, d};
        mem_i.mem[a] = v;
        exp_cc = tflags(v);
        run({op, f, d, 8'h00}, 3, 4, 1, a, 0, 16'h0000, 8'h00, 1);
      end
      `TTX_OP_PREFIX: begin
        if (d[7:6] == 2'h0) begin
          run({op, `TTX_OP_TEST_ACC, 16'h0000}, 2, 2, 0, 16'h0000, 0, 16'h0000, 8'h00, 0);
        end else begin
          a = exp_sp + {8'h00, f};
          mem_i.mem[a] = v;
          exp_cc = tflags(v);
          run({op, `TTX_OP_TEST_IDX1, f, 8'h00}, 3, 4, 1, a, 0, 16'h0000, 8'h00, 1);
        end
      end
      `TTX_OP_TEST_ACC, `TTX_OP_TEST_XLO: begin
        exp_cc = tflags((op == `TTX_OP_TEST_ACC) ? exp_a : exp_hx[7:0]);
        run({op, 24'h000000}, 1, 1, 0, 16'h0000, 0, 16'h0000, 8'h00, 1);
      end
      `TTX_OP_SP_TO_HX, `TTX_OP_HX_TO_SP, `TTX_OP_XLO_TO_ACC: begin
        if (op == `TTX_OP_SP_TO_HX) exp_hx = exp_sp + 16'h0001;
        if (op == `TTX_OP_HX_TO_SP) exp_sp = exp_hx - 16'h0001;
        if (op == `TTX_OP_XLO_TO_ACC) exp_a = exp_hx[7:0];
        run({op, 24'h000000}, 1, (op == `TTX_OP_XLO_TO_ACC) ? 1 : 2, 0, 16'h0000, 0, 16'h0000, 8'h00, 1);
      end
      `TTX_OP_MOVE_IMD: begin
        run({op, v, f, 8'h00}, 3, 4, 0, 16'h0000, 1, {8'h00, f}, v, 1);
      end
      `TTX_OP_MOVE_IDXP: begin
        a = exp_hx;
        mem_i.mem[a] = v;
        exp_hx = exp_hx + 16'h0001;
        run({op, f, 16'h0000}, 2, 4, 1, a, 1, {8'h00, f}, v, 1);
      end
      default: begin
        run({op, 24'h000000}, 1, 1, 0, 16'h0000, 0, 16'h0000, 8'h00, 0);
      end
    endcase
  endtask

  // Main sequence: reset, wrap corners, every opcode, random mix, reset again
  initial begin
    logic [7:0] ops [16];
    ops = '{`TTX_OP_TEST_DIR, `TTX_OP_TEST_ACC, `TTX_OP_TEST_XLO, `TTX_OP_TEST_IDX1, `TTX_OP_TEST_IDX,
            `TTX_OP_PREFIX, `TTX_OP_SP_TO_HX, `TTX_OP_XLO_TO_ACC, `TTX_OP_HX_TO_SP, `TTX_OP_TEST_IDX2,
            `TTX_OP_TEST_IDXP, `TTX_OP_TEST_IDX1P, `TTX_OP_MOVE_IMD, `TTX_OP_MOVE_IDXP, 8'hAB, 8'h00};
    reset_n = 1'b0;
    ins_valid = 1'b0;
    ins_byte = 8'h00;
    shadow_reset();
    repeat (16) @(posedge clk_sys);
    chk_reset();
    reset_n <= 1'b1;
    @(posedge clk_sys);
    do_op(`TTX_OP_HX_TO_SP);
    do_op(`TTX_OP_SP_TO_HX);
    do_op(`TTX_OP_HX_TO_SP);
    do_op(`TTX_OP_PREFIX);
    foreach (ops[i]) do_op(ops[i]);
    repeat (300) do_op(ops[$unsigned($random(seed)) % 16]);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_reset();
    shadow_reset();
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (ops[i]) do_op(ops[i]);
    finish_test();
  end
endmodule // test_and_transfer_ops_bench
